// ### inc/rtctoc_pkg.sv
// Package with register map, field positions and reset values of the clock control block.
package rtctoc_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  // Each register is one word, so its byte address is four times its index.
  localparam logic [5:0] CAP0_IDX = 6'h00;
  localparam logic [5:0] CAP1_IDX = 6'h01;
  localparam logic [5:0] CAP2_IDX = 6'h02;
  localparam logic [5:0] CAP3_IDX = 6'h03;
  localparam logic [5:0] CTRL_IDX = 6'h04;
  localparam logic [5:0] OSC_CONTROL_IDX = 6'h05;
  localparam logic [5:0] OSC_CONFIG_IDX = 6'h06;
  localparam logic [5:0] ALARM_IDX = 6'h08;
  localparam logic [5:0] STAT_IDX = 6'h09;
  localparam logic [7:0] CAP0_OFF = {CAP0_IDX, 2'b00};
  localparam logic [7:0] CAP1_OFF = {CAP1_IDX, 2'b00};
  localparam logic [7:0] CAP2_OFF = {CAP2_IDX, 2'b00};
  localparam logic [7:0] CAP3_OFF = {CAP3_IDX, 2'b00};
  localparam logic [7:0] CTRL_OFF = {CTRL_IDX, 2'b00};
  localparam logic [7:0] OSC_CONTROL_OFF = {OSC_CONTROL_IDX, 2'b00};
  localparam logic [7:0] OSC_CONFIG_OFF = {OSC_CONFIG_IDX, 2'b00};
  localparam logic [7:0] ALARM_OFF = {ALARM_IDX, 2'b00};
  localparam logic [7:0] STAT_OFF = {STAT_IDX, 2'b00};

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam int CTRL_SET_BIT = 1;
  localparam int CTRL_RUN_BIT = 4;
  localparam int XCN_GAIN_BIT = 7;
  localparam int XCN_MODE_BIT = 6;
  localparam int XCN_BIAS_BIT = 5;
  localparam int XCN_VALID_BIT = 4;
  localparam int XCF_STEP_BIT = 7;
  localparam int XCF_READY_BIT = 6;

  // ----------------------------------------
  // Reset values and stepper divider
  // ----------------------------------------
  localparam logic [3:0] CAP_CODE_RST = 4'h0;
  localparam logic [31:0] TIMER_RST = 32'h0000_0000;
  localparam logic [31:0] ALARM_RST = 32'h0000_0000;
  localparam int CAP_STEP_DIV = 4;

  typedef enum logic [1:0] {
    RTCTOC_IDLE = 2'b00,
    RTCTOC_SET = 2'b01,
    RTCTOC_CAP = 2'b10
  } rtctoc_op_t;

  typedef struct packed {
    logic gain_control_enable;
    logic osc_mode_select;
    logic bias_double_enable;
    logic cap_step_enable;
    logic [3:0] cap_target_code;
  } rtctoc_osc_t;

endpackage

// ### hw/rtctoc_cap_stepper.sv
// Load capacitance stepper that walks the applied code toward the target.
`timescale 1ns/100ps
module rtctoc_cap_stepper #(
  parameter int DIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic step_en,
  input wire logic [3:0] target,
  output logic [3:0] applied,
  output logic ready
);

  logic [7:0] div_r;
  logic tick;

  assign tick = (div_r == 8'(DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 8'h00;
    end else if (ce) begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
    end
  end

  // Without stepping the code is applied at once; with it, one step per tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied <= 4'h0;
    end else if (ce) begin
      if (!step_en) begin
        applied <= target;
      end else if (tick && applied < target) begin
        applied <= applied + 4'h1;
      end else if (tick && applied > target) begin
        applied <= applied - 4'h1;
      end
    end
  end

  assign ready = (applied == target);

endmodule

// ### hw/rtctoc_top.sv
// APB slave holding the real-time clock timer, set/capture handshake and oscillator registers.
`timescale 1ns/100ps
// ----------------------------------------
// ----------------------------------------
module rtctoc_top #(
  parameter logic [3:0] CAP_CODE_RESET = rtctoc_pkg::CAP_CODE_RST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic rtc_tick,
  input wire logic amplitude_ok,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output rtctoc_pkg::rtctoc_osc_t osc_ctl,
  output logic [3:0] cap_applied,
  output logic [31:0] timer_value,
  output logic alarm_event_flag
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] tick_sync_r;
  logic [1:0] amp_sync_r;
  logic tick_prev_r;
  logic tick_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_sync_r <= 2'b00;
      amp_sync_r <= 2'b00;
      tick_prev_r <= 1'b0;
    end else if (ce) begin
      tick_sync_r <= {tick_sync_r[0], rtc_tick};
      amp_sync_r <= {amp_sync_r[0], amplitude_ok};
      tick_prev_r <= tick_sync_r[1];
    end
  end

  assign tick_rise = tick_sync_r[1] & ~tick_prev_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wr;
  logic rd;
  logic mapped;

  assign pready = 1'b1;
  assign wr = psel & penable & pwrite & ce;
  assign rd = psel & penable & ~pwrite & ce;
  always_comb begin
    unique case (paddr)
      rtctoc_pkg::CAP0_OFF, rtctoc_pkg::CAP1_OFF, rtctoc_pkg::CAP2_OFF, rtctoc_pkg::CAP3_OFF,
      rtctoc_pkg::CTRL_OFF, rtctoc_pkg::OSC_CONTROL_OFF, rtctoc_pkg::OSC_CONFIG_OFF,
      rtctoc_pkg::ALARM_OFF, rtctoc_pkg::STAT_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------
  // Control register and operations
  // ----------------------------------------
  logic run_r;
  logic auto_reset_r;
  rtctoc_pkg::rtctoc_op_t op_r;
  logic [31:0] cap_r;
  logic [31:0] alarm_r;
  logic alarm_en_r;
  logic alarm_hit;
  logic ctrl_wr;

  assign ctrl_wr = wr && paddr == rtctoc_pkg::CTRL_OFF;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      alarm_en_r <= 1'b0;
      auto_reset_r <= 1'b0;
    end else if (ce && ctrl_wr) begin
      run_r <= pwdata[rtctoc_pkg::CTRL_RUN_BIT];
      alarm_en_r <= pwdata[3];
      auto_reset_r <= pwdata[2];
    end
  end

  // Operations are taken in the cycle after the write and finish in that cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= rtctoc_pkg::RTCTOC_IDLE;
    end else if (ce) begin
      unique case (op_r)
        rtctoc_pkg::RTCTOC_IDLE: begin
          if (ctrl_wr && pwdata[rtctoc_pkg::CTRL_SET_BIT]) begin
            op_r <= rtctoc_pkg::RTCTOC_SET;
          end else if (ctrl_wr && pwdata[rtctoc_pkg::CTRL_CAPTURE_BIT]) begin
            op_r <= rtctoc_pkg::RTCTOC_CAP;
          end
        end
        rtctoc_pkg::RTCTOC_SET: op_r <= rtctoc_pkg::RTCTOC_IDLE;
        rtctoc_pkg::RTCTOC_CAP: op_r <= rtctoc_pkg::RTCTOC_IDLE;
        default: op_r <= rtctoc_pkg::RTCTOC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Timer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_value <= rtctoc_pkg::TIMER_RST;
    end else if (ce) begin
      if (op_r == rtctoc_pkg::RTCTOC_SET) begin
        timer_value <= cap_r;
      end else if (run_r && tick_rise) begin
        timer_value <= timer_value + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_r <= rtctoc_pkg::TIMER_RST;
    end else if (ce) begin
      if (op_r == rtctoc_pkg::RTCTOC_CAP) begin
        cap_r <= timer_value;
      end else if (wr && paddr == rtctoc_pkg::CAP0_OFF) begin
        cap_r[7:0] <= pwdata[7:0];
      end else if (wr && paddr == rtctoc_pkg::CAP1_OFF) begin
        cap_r[15:8] <= pwdata[7:0];
      end else if (wr && paddr == rtctoc_pkg::CAP2_OFF) begin
        cap_r[23:16] <= pwdata[7:0];
      end else if (wr && paddr == rtctoc_pkg::CAP3_OFF) begin
        cap_r[31:24] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_r <= rtctoc_pkg::ALARM_RST;
    end else if (ce && wr && paddr == rtctoc_pkg::ALARM_OFF) begin
      alarm_r <= pwdata;
    end
  end

  // ----------------------------------------
  // Alarm flag
  // ----------------------------------------
  assign alarm_hit = alarm_en_r && run_r && tick_rise && (timer_value == alarm_r);

  // The flag rises on a match tick and drops at the next tick at the latest.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_event_flag <= 1'b0;
    end else if (ce) begin
      if (alarm_hit) begin
        alarm_event_flag <= 1'b1;
      end else if (tick_rise || !alarm_en_r) begin
        alarm_event_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Oscillator registers
  // ----------------------------------------
  logic cap_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ctl.gain_control_enable <= 1'b0;
      osc_ctl.osc_mode_select <= 1'b0;
      osc_ctl.bias_double_enable <= 1'b0;
    end else if (ce && wr && paddr == rtctoc_pkg::OSC_CONTROL_OFF) begin
      osc_ctl.gain_control_enable <= pwdata[rtctoc_pkg::XCN_GAIN_BIT];
      osc_ctl.osc_mode_select <= pwdata[rtctoc_pkg::XCN_MODE_BIT];
      osc_ctl.bias_double_enable <= pwdata[rtctoc_pkg::XCN_BIAS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ctl.cap_step_enable <= 1'b0;
      osc_ctl.cap_target_code <= CAP_CODE_RESET;
    end else if (ce && wr && paddr == rtctoc_pkg::OSC_CONFIG_OFF) begin
      osc_ctl.cap_step_enable <= pwdata[rtctoc_pkg::XCF_STEP_BIT];
      osc_ctl.cap_target_code <= pwdata[3:0];
    end
  end

  rtctoc_cap_stepper #(
    .DIV(rtctoc_pkg::CAP_STEP_DIV)
  ) u_stepper (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .step_en(osc_ctl.cap_step_enable),
    .target(osc_ctl.cap_target_code),
    .applied(cap_applied),
    .ready(cap_ready)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      unique case (paddr)
        rtctoc_pkg::CAP0_OFF: prdata <= {24'h000000, cap_r[7:0]};
        rtctoc_pkg::CAP1_OFF: prdata <= {24'h000000, cap_r[15:8]};
        rtctoc_pkg::CAP2_OFF: prdata <= {24'h000000, cap_r[23:16]};
        rtctoc_pkg::CAP3_OFF: prdata <= {24'h000000, cap_r[31:24]};
        rtctoc_pkg::CTRL_OFF: prdata <= {24'h000000, 3'h0, run_r, alarm_en_r, alarm_event_flag,
                                         op_r == rtctoc_pkg::RTCTOC_SET, op_r == rtctoc_pkg::RTCTOC_CAP};
        rtctoc_pkg::OSC_CONTROL_OFF: prdata <= {24'h000000, osc_ctl.gain_control_enable,
                                                osc_ctl.osc_mode_select, osc_ctl.bias_double_enable,
                                                amp_sync_r[1], 4'h0};
        rtctoc_pkg::OSC_CONFIG_OFF: prdata <= {24'h000000, osc_ctl.cap_step_enable, cap_ready, 2'b00,
                                               osc_ctl.cap_target_code};
        rtctoc_pkg::ALARM_OFF: prdata <= alarm_r;
        rtctoc_pkg::STAT_OFF: prdata <= {28'h0000000, cap_applied};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_set_clears: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ctrl_wr && pwdata[rtctoc_pkg::CTRL_SET_BIT] && op_r == rtctoc_pkg::RTCTOC_IDLE
    |=> op_r == rtctoc_pkg::RTCTOC_SET ##1 op_r == rtctoc_pkg::RTCTOC_IDLE)
    else $error("set operation did not finish");
  a_cap_loads: assert property (@(posedge pclk) disable iff (!presetn)
    ce && op_r == rtctoc_pkg::RTCTOC_CAP |=> cap_r == $past(timer_value))
    else $error("capture lost timer value");
  a_set_loads: assert property (@(posedge pclk) disable iff (!presetn)
    ce && op_r == rtctoc_pkg::RTCTOC_SET |=> timer_value == $past(cap_r))
    else $error("set lost capture value");
  a_alarm_short: assert property (@(posedge pclk) disable iff (!presetn)
    ce && alarm_event_flag && tick_rise && !alarm_hit |=> !alarm_event_flag)
    else $error("alarm flag outlived one tick");
  a_run_holds: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !run_r && op_r != rtctoc_pkg::RTCTOC_SET |=> timer_value == $past(timer_value))
    else $error("timer moved while stopped");
  a_gain_wr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr && paddr == rtctoc_pkg::OSC_CONTROL_OFF
    |=> osc_ctl.gain_control_enable == $past(pwdata[rtctoc_pkg::XCN_GAIN_BIT]))
    else $error("gain enable not written");
  a_step_wr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr && paddr == rtctoc_pkg::OSC_CONFIG_OFF |=> osc_ctl.cap_target_code == $past(pwdata[3:0]))
    else $error("target code not written");
  a_ready_match: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !osc_ctl.cap_step_enable && !(wr && paddr == rtctoc_pkg::OSC_CONFIG_OFF) |=> cap_ready)
    else $error("ready low with stepping off");

endmodule

// ### verif/tb_top.sv
// Self-checking testbench for the clock timer and oscillator control block.
`timescale 1ns/100ps
module tb_top;
  logic pclk, presetn, ce, rtc_tick, amplitude_ok;
  logic psel, penable, pwrite, pready, pslverr, alarm_event_flag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, timer_value, rd;
  logic [3:0] cap_applied;
  rtctoc_pkg::rtctoc_osc_t osc_ctl;
  logic err;
  int n_errors, n_checks, cyc, run_len, max_len;
  logic seen;

  rtctoc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .rtc_tick(rtc_tick),
    .amplitude_ok(amplitude_ok), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_ctl(osc_ctl), .cap_applied(cap_applied),
    .timer_value(timer_value), .alarm_event_flag(alarm_event_flag));

  // ----------------------------------------
  // Clock, timeout and alarm pulse monitor
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (alarm_event_flag === 1'b1) begin
      seen = 1'b1;
      run_len++;
      if (run_len > max_len) max_len = run_len;
    end else begin
      run_len = 0;
    end
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      rtc_tick <= 1'b1;
      repeat (4) @(posedge pclk);
      rtc_tick <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask

  task automatic wait_done(input int b);
    int i;
    for (i = 0; i < 10; i++) begin
      apb(1'b0, rtctoc_pkg::CTRL_OFF, 32'h0);
      if (rd[b] === 1'b0) break;
    end
    chk("ctrl go bit", 32'h0, {31'h0, rd[b]});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_osc_control();
    apb(1'b0, rtctoc_pkg::OSC_CONTROL_OFF, 32'h0);
    chk("osc_control reset", 32'h0, rd);
    apb(1'b1, rtctoc_pkg::OSC_CONTROL_OFF, 32'hff);
    apb(1'b0, rtctoc_pkg::OSC_CONTROL_OFF, 32'h0);
    chk("osc_control all ones", 32'he0, rd);
    chk("osc_ctl outputs", 32'h7, {29'h0, osc_ctl.gain_control_enable, osc_ctl.osc_mode_select,
      osc_ctl.bias_double_enable});
    amplitude_ok <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, rtctoc_pkg::OSC_CONTROL_OFF, 32'h40);
    apb(1'b0, rtctoc_pkg::OSC_CONTROL_OFF, 32'h0);
    chk("osc_control valid", 32'h50, rd);
  endtask

  task automatic t_osc_config();
    apb(1'b0, rtctoc_pkg::OSC_CONFIG_OFF, 32'h0);
    chk("osc_config reset", {24'h0, 1'b0, 1'b1, 2'b00, rtctoc_pkg::CAP_CODE_RST}, rd);
    apb(1'b1, rtctoc_pkg::OSC_CONFIG_OFF, 32'hb9);
    apb(1'b0, rtctoc_pkg::OSC_CONFIG_OFF, 32'h0);
    chk("osc_config stepping", 32'h89, rd);
    chk("osc_ctl config", 32'h19, {27'h0, osc_ctl.cap_step_enable, osc_ctl.cap_target_code});
    repeat (60) @(posedge pclk);
    apb(1'b0, rtctoc_pkg::OSC_CONFIG_OFF, 32'h0);
    chk("osc_config ready", 32'hc9, rd);
    chk("applied code", 32'h9, {28'h0, cap_applied});
  endtask

  task automatic t_set_run_capture();
    logic [31:0] v;
    logic [31:0] w;
    int i;
    v = 32'h1234_56fd;
    for (i = 0; i < 4; i++) apb(1'b1, 8'(4 * i), {24'h0, v[8*i +: 8]});
    apb(1'b1, rtctoc_pkg::CTRL_OFF, 32'h02);
    wait_done(rtctoc_pkg::CTRL_SET_BIT);
    chk("timer after set", v, timer_value);
    ticks(3);
    chk("timer stopped", v, timer_value);
    apb(1'b1, rtctoc_pkg::CTRL_OFF, 32'h10);
    ticks(5);
    chk("timer running", v + 32'd5, timer_value);
    ce <= 1'b0;
    ticks(2);
    ce <= 1'b1;
    chk("timer frozen", v + 32'd5, timer_value);
    apb(1'b1, rtctoc_pkg::CTRL_OFF, 32'h01);
    wait_done(rtctoc_pkg::CTRL_CAPTURE_BIT);
    w = v + 32'd5;
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("capture byte", {24'h0, w[8*i +: 8]}, rd);
    end
  endtask

  task automatic t_alarm();
    apb(1'b1, rtctoc_pkg::ALARM_OFF, 32'h1234_5705);
    seen = 1'b0;
    max_len = 0;
    apb(1'b1, rtctoc_pkg::CTRL_OFF, 32'h18);
    ticks(8);
    chk("alarm seen", 32'h1, {31'h0, seen});
    chk("alarm width ok", 32'h1, {31'h0, max_len <= 8});
    apb(1'b1, rtctoc_pkg::CTRL_OFF, 32'h0);
  endtask

  task automatic t_unmapped();
    apb(1'b1, 8'h30, 32'hffff_ffff);
    chk("unmapped write err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped read err", 32'h1, {31'h0, err});
    chk("unmapped read data", 32'h0, rd);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    rtc_tick = 1'b0;
    amplitude_ok = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_osc_control();
    t_osc_config();
    t_set_run_capture();
    t_alarm();
    t_unmapped();
    print_verdict();
  end
endmodule
